/* File: hdl/evcnt_unit.sv */
// Chosen here: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module evcnt_unit (
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  input wire logic [7:0] i_awaddr,
  input wire logic [2:0] i_awprot,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [7:0] i_araddr,
  input wire logic [2:0] i_arprot,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  input wire evcnt_pkg::evcnt_event_t i_events,
  input wire evcnt_pkg::evcnt_err_t i_errors,
  input wire logic i_secure_debug_count_enable,
  output logic [8:0] o_irq_lines,
  output logic o_combined_irq_out
);
  import evcnt_pkg::*;

  // Address decode shared by both channels
  function automatic evcnt_reg_t reg_of(input logic [7:0] a);
    evcnt_reg_t r;
    r = REG_NONE;
    if (a == OFF_CTRL) r = REG_CTRL;
    else if (a == OFF_CFG0) r = REG_CFG0;
    else if (a == OFF_CFG1) r = REG_CFG1;
    else if (a == OFF_VAL0) r = REG_VAL0;
    else if (a == OFF_VAL1) r = REG_VAL1;
    else if (a == OFF_MASK) r = REG_MASK;
    else if (a == OFF_MSTAT) r = REG_MSTAT;
    else if (a == OFF_RAW) r = REG_RAW;
    else if (a == OFF_CLR) r = REG_CLR;
    else if (a == OFF_AUX) r = REG_AUX;
    return r;
  endfunction

  logic aw_got_ff, w_got_ff, awready_ff, wready_ff, bvalid_ff;
  logic arready_ff, rvalid_ff;
  logic [1:0] bresp_ff, rresp_ff;
  logic [31:0] rdata_ff;
  logic [7:0] wr_addr_ff;
  logic [2:0] wr_prot_ff;
  logic [31:0] wr_data_ff;
  logic [3:0] wr_strb_ff;
  logic en_ff, aux_ns_ff;
  logic [5:0] cfg_ff [N_CNT];
  logic [31:0] cnt_ff [N_CNT];
  logic [8:0] mask_ff, raw_ff, irq_ff;
  logic comb_ff, dbg_meta_ff, dbg_sync_ff;
  logic [N_CNT-1:0] inc, ovf, clr, pre, cirq;

  // Write channel handshakes
  wire aw_fire = i_awvalid & awready_ff;
  wire w_fire = i_wvalid & wready_ff;
  wire wr_do = aw_got_ff & w_got_ff & ~bvalid_ff;
  wire nxt_aw_got = (aw_got_ff | aw_fire) & ~wr_do;
  wire nxt_w_got = (w_got_ff | w_fire) & ~wr_do;
  wire nxt_bvalid = wr_do | (bvalid_ff & ~i_bready);

  // Write decode and access check; mask and clear are guarded by bit 27
  wire evcnt_reg_t wr_reg = reg_of(wr_addr_ff);
  wire wr_ns = wr_prot_ff[PROT_NS_BIT];
  wire wr_guard = (wr_reg == REG_MASK) | (wr_reg == REG_CLR);
  wire wr_deny = wr_ns & ((wr_guard & ~aux_ns_ff) | (wr_reg == REG_AUX));
  wire wr_ro = (wr_reg == REG_MSTAT) | (wr_reg == REG_RAW);
  wire wr_ok = wr_do & ~wr_deny & ~wr_ro & (wr_reg != REG_NONE);
  wire [31:0] wmask = {{8{wr_strb_ff[3]}}, {8{wr_strb_ff[2]}},
                       {8{wr_strb_ff[1]}}, {8{wr_strb_ff[0]}}};
  wire [31:0] wdat = wr_data_ff & wmask;
  wire [1:0] wr_resp = (wr_reg == REG_NONE) ? RESP_DECERR :
                       (wr_deny | wr_ro) ? RESP_SLVERR : RESP_OKAY;

  // Write channel state; both halves are held until the reply is taken
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
      awready_ff <= 1'b0;
      wready_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
    end else begin
      aw_got_ff <= nxt_aw_got;
      w_got_ff <= nxt_w_got;
      awready_ff <= ~nxt_aw_got & ~nxt_bvalid;
      wready_ff <= ~nxt_w_got & ~nxt_bvalid;
      bvalid_ff <= nxt_bvalid;
      if (wr_do) bresp_ff <= wr_resp;
    end
  end

  // Write payload capture
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      wr_addr_ff <= 8'h00;
      wr_prot_ff <= 3'h0;
      wr_data_ff <= 32'h0000_0000;
      wr_strb_ff <= 4'h0;
    end else begin
      if (aw_fire) wr_addr_ff <= {i_awaddr[7:2], 2'b00};
      if (aw_fire) wr_prot_ff <= i_awprot;
      if (w_fire) wr_data_ff <= i_wdata;
      if (w_fire) wr_strb_ff <= i_wstrb;
    end
  end

  // Read decode; one cycle from address to data
  wire ar_fire = i_arvalid & arready_ff;
  wire nxt_rvalid = ar_fire | (rvalid_ff & ~i_rready);
  wire evcnt_reg_t rd_reg = reg_of({i_araddr[7:2], 2'b00});
  wire rd_ns = i_arprot[PROT_NS_BIT];
  wire rd_deny = rd_ns & ~aux_ns_ff & (rd_reg == REG_MASK);
  logic [31:0] rd_val;
  logic [1:0] rd_resp;

  // Read mux; reserved bits are padded with zero
  always_comb begin
    rd_val = 32'h0000_0000;
    rd_resp = RESP_OKAY;
    case (rd_reg)
      REG_CTRL: rd_val = {31'h0, en_ff};
      REG_CFG0: rd_val = {26'h0, cfg_ff[0]};
      REG_CFG1: rd_val = {26'h0, cfg_ff[1]};
      REG_VAL0: rd_val = cnt_ff[0];
      REG_VAL1: rd_val = cnt_ff[1];
      REG_MASK: rd_val = rd_deny ? 32'h0000_0000 : {23'h0, mask_ff};
      REG_MSTAT: rd_val = {23'h0, raw_ff & mask_ff};
      REG_RAW: rd_val = {23'h0, raw_ff};
      REG_AUX: rd_val = {4'h0, aux_ns_ff, 27'h0};
      REG_CLR: rd_resp = RESP_SLVERR;
      default: rd_resp = RESP_DECERR;
    endcase
    if (rd_deny) rd_resp = RESP_SLVERR;
  end

  // Read channel state
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= RESP_OKAY;
    end else begin
      arready_ff <= ~nxt_rvalid;
      rvalid_ff <= nxt_rvalid;
      if (ar_fire) rdata_ff <= rd_val;
      if (ar_fire) rresp_ff <= rd_resp;
    end
  end

  // Debug pin comes from outside, so it is synchronised before use
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      dbg_meta_ff <= 1'b0;
      dbg_sync_ff <= 1'b0;
    end else begin
      dbg_meta_ff <= i_secure_debug_count_enable;
      dbg_sync_ff <= dbg_meta_ff;
    end
  end

  // Global enable and auxiliary access bit
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      en_ff <= RST_EN;
      aux_ns_ff <= RST_AUX_NS;
    end else begin
      if (wr_ok && wr_reg == REG_CTRL && wr_strb_ff[0]) en_ff <= wdat[CTRL_EN_BIT];
      if (wr_ok && wr_reg == REG_AUX && wr_strb_ff[3]) aux_ns_ff <= wdat[AUX_NSIRQ_BIT];
    end
  end

  // Per counter: source select, clear, preload, count and wrap
  for (genvar g = 0; g < N_CNT; g++) begin : g_cnt
    wire evcnt_reg_t my_cfg = (g == 0) ? REG_CFG0 : REG_CFG1;
    wire evcnt_reg_t my_val = (g == 0) ? REG_VAL0 : REG_VAL1;
    wire [3:0] src = cfg_ff[g][CFG_SRC_LSB +: 4];
    wire [1:0] gen = cfg_ff[g][CFG_GEN_LSB +: 2];
    wire src_ok = (src >= SRC_FIRST) && (src <= SRC_LAST);
    wire [3:0] idx = src_ok ? (src - SRC_FIRST) : 4'h0;
    wire sec_ok = ~i_events.secure[idx] | dbg_sync_ff;
    logic [31:0] nxt_cnt;
    logic [5:0] nxt_cfg;
    assign inc[g] = en_ff & src_ok & i_events.hit[idx] & sec_ok;
    assign ovf[g] = inc[g] & (&cnt_ff[g]);
    assign clr[g] = wr_ok & (wr_reg == REG_CTRL) & wdat[CTRL_RST_LSB + g];
    assign pre[g] = wr_ok & (wr_reg == my_val) & ~src_ok;
    // Code 11 and 00 both fall through to no interrupt
    assign cirq[g] = ((gen == GEN_INC) & inc[g]) | ((gen == GEN_OVF) & ovf[g]);

    // Clear beats preload beats count; preload and count never meet
    always_comb begin
      nxt_cnt = cnt_ff[g];
      if (clr[g]) nxt_cnt = RST_CNT;
      else if (pre[g]) nxt_cnt = (cnt_ff[g] & ~wmask) | wdat;
      else if (inc[g]) nxt_cnt = cnt_ff[g] + 32'h0000_0001;
      nxt_cfg = cfg_ff[g];
      if (wr_ok && wr_reg == my_cfg && wr_strb_ff[0]) nxt_cfg = wdat[CFG_W-1:0];
    end

    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
        cnt_ff[g] <= RST_CNT;
        cfg_ff[g] <= RST_CFG;
      end else begin
        cnt_ff[g] <= nxt_cnt;
        cfg_ff[g] <= nxt_cfg;
      end
    end
  end

  // Raw status: a new event wins over a clear in the same cycle
  wire [8:0] irq_set = {i_errors, |cirq};
  wire clr_ok = wr_ok & (wr_reg == REG_CLR);
  wire [8:0] irq_clr = clr_ok ? wdat[8:0] : 9'h000;
  wire [8:0] nxt_raw = (raw_ff & ~irq_clr) | irq_set;
  wire mask_wr = wr_ok & (wr_reg == REG_MASK);
  wire [8:0] nxt_mask = mask_wr ? ((mask_ff & ~wmask[8:0]) | wdat[8:0]) : mask_ff;
  wire [8:0] nxt_irq = nxt_raw & nxt_mask;

  // Interrupt state; outputs are built from next values to stay in step
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      raw_ff <= RST_RAW;
      mask_ff <= RST_MASK;
      irq_ff <= 9'h000;
      comb_ff <= 1'b0;
    end else begin
      raw_ff <= nxt_raw;
      mask_ff <= nxt_mask;
      irq_ff <= nxt_irq;
      comb_ff <= |nxt_irq;
    end
  end

  assign o_awready = awready_ff;
  assign o_wready = wready_ff;
  assign o_bvalid = bvalid_ff;
  assign o_bresp = bresp_ff;
  assign o_arready = arready_ff;
  assign o_rvalid = rvalid_ff;
  assign o_rdata = rdata_ff;
  assign o_rresp = rresp_ff;
  assign o_irq_lines = irq_ff;
  assign o_combined_irq_out = comb_ff;

  // Checks on the block's own behaviour
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_reset_n);

  sequence s_wr_taken;
    wr_do;
  endsequence
  sequence s_wr_reply;
    o_bvalid [*1] ##0 (o_awready == 1'b0);
  endsequence

  sequence s_rd_reply;
    o_rvalid ##0 (o_arready == 1'b0);
  endsequence

  a_write_reply: assert property (s_wr_taken |=> s_wr_reply)
    else $error("write reply missing");
  a_ctrl_raz: assert property (ar_fire && rd_reg == REG_CTRL
      |=> o_rdata[31:1] == 31'h0000_0000)
    else $error("control reset bits not zero");
  a_masked_read: assert property (ar_fire && rd_reg == REG_MSTAT
      |=> o_rdata == {23'h0, $past(raw_ff & mask_ff)})
    else $error("masked status wrong");
  a_irq_gate: assert property (o_irq_lines == (raw_ff & mask_ff)
      && o_combined_irq_out == |(raw_ff & mask_ff))
    else $error("irq lines not gated by mask");
  a_mask_ns_deny: assert property (wr_do && wr_ns && !aux_ns_ff && wr_reg == REG_MASK
      |=> $stable(mask_ff) ##0 o_bresp == RESP_SLVERR)
    else $error("non-secure mask write got through");
  a_clear_raw: assert property (clr_ok && wdat[8] && !i_errors.decode_err
      |=> !raw_ff[8])
    else $error("raw bit not cleared");
  a_set_wins: assert property (clr_ok && wdat[8] && i_errors.decode_err |=> raw_ff[8])
    else $error("set lost to clear");
  a_idle_hold: assert property (!en_ff && !clr[0] && !pre[0] |=> $stable(cnt_ff[0]))
    else $error("counter moved while idle");
  a_count_step: assert property (inc[1] && !clr[1] |=> cnt_ff[1] == $past(cnt_ff[1]) + 1)
    else $error("counter did not add one");
  a_counter_clear: assert property (clr[0] |=> cnt_ff[0] == 32'h0000_0000)
    else $error("counter not cleared");
  a_secure_block: assert property (!dbg_sync_ff
      && (i_events.hit & ~i_events.secure) == 9'h000 |-> inc == 2'h0)
    else $error("secure event counted");
  a_wrap_zero: assert property (ovf[1] && !clr[1] |=> cnt_ff[1] == 32'h0000_0000)
    else $error("counter did not wrap");
  a_gen_off: assert property (cfg_ff[1][1:0] == 2'b11 |-> !cirq[1])
    else $error("code 11 raised interrupt");
  a_cnt_status: assert property (cirq != 2'b00 |=> raw_ff[0])
    else $error("counter status not set");
  a_preload_block: assert property (wr_ok && wr_reg == REG_VAL0
      && cfg_ff[0][5:2] == 4'h1 && !clr[0] && !inc[0] |=> $stable(cnt_ff[0]))
    else $error("preload while source active");

  // Further checks on replies, counters and status
  a_read_reply: assert property (ar_fire |=> s_rd_reply)
    else $error("read reply missing");
  a_enable_write: assert property (wr_ok && wr_reg == REG_CTRL && wr_strb_ff[0]
      |=> en_ff == $past(wr_data_ff[CTRL_EN_BIT]))
    else $error("enable bit not written");
  a_clear_ns_deny: assert property (wr_do && wr_ns && !aux_ns_ff && wr_reg == REG_CLR
      && i_errors == 8'h00 && cirq == 2'h0
      |=> raw_ff == $past(raw_ff) ##0 o_bresp == RESP_SLVERR)
    else $error("non-secure clear got through");
  a_mask_ns_read: assert property (ar_fire && rd_reg == REG_MASK && rd_ns && !aux_ns_ff
      |=> o_rresp == RESP_SLVERR && o_rdata == 32'h0000_0000)
    else $error("non-secure mask read got through");
  a_counter1_clear: assert property (clr[1] |=> cnt_ff[1] == 32'h0000_0000)
    else $error("second counter not cleared");
  a_src_off: assert property (cfg_ff[0][5:2] == 4'h0 || cfg_ff[0][5:2] > SRC_LAST
      |-> !inc[0])
    else $error("disabled source counted");
  a_value_read: assert property (ar_fire && rd_reg == REG_VAL1
      |=> o_rdata == $past(cnt_ff[1]))
    else $error("value read wrong");
  a_preload_take: assert property (pre[1] && !clr[1] && wr_strb_ff == 4'hf
      |=> cnt_ff[1] == $past(wr_data_ff))
    else $error("preload not taken");
  a_combined_or: assert property (o_combined_irq_out == |o_irq_lines)
    else $error("combined line not the OR of lines");
  a_gen_inc: assert property (inc[0] && cfg_ff[0][1:0] == GEN_INC |-> cirq[0])
    else $error("increment interrupt missing");
  a_gen_ovf: assert property (ovf[1] && cfg_ff[1][1:0] == GEN_OVF |-> cirq[1])
    else $error("overflow interrupt missing");
endmodule // evcnt_unit
`default_nettype wire

/* File: shared/evcnt_pkg.sv */
`default_nettype none
package evcnt_pkg;
  // Sizes of the block
  localparam int unsigned N_CNT = 2;
  localparam int unsigned N_IRQ = 9;
  localparam int unsigned CNT_W = 32;
  // Register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_CFG0 = 8'h04;
  localparam logic [7:0] OFF_CFG1 = 8'h08;
  localparam logic [7:0] OFF_VAL0 = 8'h0c;
  localparam logic [7:0] OFF_VAL1 = 8'h10;
  localparam logic [7:0] OFF_MASK = 8'h14;
  localparam logic [7:0] OFF_MSTAT = 8'h18;
  localparam logic [7:0] OFF_RAW = 8'h1c;
  localparam logic [7:0] OFF_CLR = 8'h20;
  localparam logic [7:0] OFF_AUX = 8'h24;
  // Field positions
  localparam int unsigned CTRL_EN_BIT = 0;
  localparam int unsigned CTRL_RST_LSB = 1;
  localparam int unsigned CFG_GEN_LSB = 0;
  localparam int unsigned CFG_SRC_LSB = 2;
  localparam int unsigned CFG_W = 6;
  localparam int unsigned AUX_NSIRQ_BIT = 27;
  localparam int unsigned PROT_NS_BIT = 1;
  // Field codes
  localparam logic [3:0] SRC_FIRST = 4'h1;
  localparam logic [3:0] SRC_LAST = 4'h9;
  localparam logic [1:0] GEN_INC = 2'h1;
  localparam logic [1:0] GEN_OVF = 2'h2;
  // Reset values
  localparam logic RST_EN = 1'h0;
  localparam logic [5:0] RST_CFG = 6'h00;
  localparam logic [31:0] RST_CNT = 32'h0000_0000;
  localparam logic [8:0] RST_MASK = 9'h000;
  localparam logic [8:0] RST_RAW = 9'h000;
  localparam logic RST_AUX_NS = 1'h0;
  // Bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  // Decoded register identity
  typedef enum logic [3:0] {
    REG_NONE, REG_CTRL, REG_CFG0, REG_CFG1, REG_VAL0, REG_VAL1,
    REG_MASK, REG_MSTAT, REG_RAW, REG_CLR, REG_AUX
  } evcnt_reg_t;
  // Cache event pulses, bit k-1 selected by source code k
  typedef struct packed {
    logic [8:0] hit;
    logic [8:0] secure;
  } evcnt_event_t;
  // Error sources, packed so they land on raw status bits 8..1
  typedef struct packed {
    logic decode_err;
    logic slave_err;
    logic data_ram_read_error;
    logic tag_ram_read_error;
    logic data_ram_write_error;
    logic tag_ram_write_error;
    logic data_ram_parity_error;
    logic tag_ram_parity_error;
  } evcnt_err_t;
endpackage
`default_nettype wire

/* File: verif/evcnt_unit_test.sv */
`timescale 1ns/1ps
`default_nettype none
module evcnt_unit_test;
  import evcnt_pkg::*;
  localparam logic [2:0] SEC = 3'h0;
  localparam logic [2:0] NSEC = 3'h2;
  logic i_core_clk, i_reset_n, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
  logic [7:0] i_awaddr, i_araddr;
  logic [2:0] i_awprot, i_arprot;
  logic [31:0] i_wdata, o_rdata, pre;
  logic [3:0] i_wstrb;
  logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_combined_irq_out;
  logic [1:0] o_bresp, o_rresp;
  logic [8:0] o_irq_lines, msk, raw;
  evcnt_event_t i_events;
  evcnt_err_t i_errors;
  logic i_secure_debug_count_enable;
  int fails, num_checks, seed, n;

  evcnt_unit i_evcnt_unit (.i_core_clk(i_core_clk), .i_reset_n(i_reset_n),
    .i_awaddr(i_awaddr), .i_awprot(i_awprot), .i_awvalid(i_awvalid), .o_awready(o_awready),
    .i_wdata(i_wdata), .i_wstrb(i_wstrb), .i_wvalid(i_wvalid), .o_wready(o_wready),
    .o_bresp(o_bresp), .o_bvalid(o_bvalid), .i_bready(i_bready), .i_araddr(i_araddr),
    .i_arprot(i_arprot), .i_arvalid(i_arvalid), .o_arready(o_arready), .o_rdata(o_rdata),
    .o_rresp(o_rresp), .o_rvalid(o_rvalid), .i_rready(i_rready), .i_events(i_events),
    .i_errors(i_errors), .i_secure_debug_count_enable(i_secure_debug_count_enable),
    .o_irq_lines(o_irq_lines), .o_combined_irq_out(o_combined_irq_out));

  // Free-running core clock, 100 ns period
  initial begin
    i_core_clk = 1'b0;
    forever #50 i_core_clk = ~i_core_clk;
  end

  // Expected count: secure events only add while the debug pin is high
  function automatic logic [31:0] f_cnt(logic [31:0] b, int c, logic s, logic dbg);
    return (s && !dbg) ? b : b + 32'(c);
  endfunction

  // Expected masked view of the raw status
  function automatic logic [31:0] f_msk(logic [8:0] r, logic [8:0] m);
    return {23'h0, r & m};
  endfunction

  task automatic end_sim;
    if (fails == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // One write; valids drop once taken, bready stays up until the answer
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [2:0] p,
                    input logic [1:0] er);
    @(posedge i_core_clk);
    i_awaddr <= a;
    i_awprot <= p;
    i_awvalid <= 1'b1;
    i_wdata <= d;
    i_wstrb <= 4'hf;
    i_wvalid <= 1'b1;
    i_bready <= 1'b1;
    do begin
      @(posedge i_core_clk);
      if (o_awready) i_awvalid <= 1'b0;
      if (o_wready) i_wvalid <= 1'b0;
    end while (!o_bvalid);
    i_bready <= 1'b0;
    chk({30'h0, o_bresp}, {30'h0, er});
  endtask

  // One read compared against data and response
  task automatic rd(input logic [7:0] a, input logic [2:0] p, input logic [31:0] ed,
                    input logic [1:0] er);
    @(posedge i_core_clk);
    i_araddr <= a;
    i_arprot <= p;
    i_arvalid <= 1'b1;
    i_rready <= 1'b1;
    do begin
      @(posedge i_core_clk);
      if (o_arready) i_arvalid <= 1'b0;
    end while (!o_rvalid);
    i_rready <= 1'b0;
    chk(o_rdata, ed);
    chk({30'h0, o_rresp}, {30'h0, er});
  endtask

  // Holds one event source high for cnt cycles; each high cycle is one occurrence
  task automatic hits(input int k, input logic s, input int cnt);
    @(posedge i_core_clk);
    i_events.hit[k] <= 1'b1;
    i_events.secure[k] <= s;
    repeat (cnt) @(posedge i_core_clk);
    i_events.hit[k] <= 1'b0;
    repeat (2) @(posedge i_core_clk);
  endtask

  task automatic irq_chk(input logic [8:0] e);
    @(posedge i_core_clk);
    chk({23'h0, o_irq_lines}, {23'h0, e});
    chk({31'h0, o_combined_irq_out}, {31'h0, |e});
  endtask

  // Watchdog sized well above the several hundred cycles the sequence needs
  initial begin
    repeat (20000) @(posedge i_core_clk);
    fails++;
    end_sim();
  end

  // Main sequence
  initial begin
    seed = 37765;
    fails = 0;
    num_checks = 0;
    {i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} = 5'h00;
    {i_awaddr, i_araddr, i_awprot, i_arprot, i_wstrb} = 26'h0;
    i_wdata = 32'h0;
    i_events = '0;
    i_errors = '0;
    i_secure_debug_count_enable = 1'b0;
    i_reset_n = 1'b0;
    repeat (3) @(posedge i_core_clk);
    i_reset_n <= 1'b1;
    repeat (2) @(posedge i_core_clk);
    rd(OFF_CTRL, SEC, 32'h0, RESP_OKAY);
    rd(OFF_CFG1, NSEC, 32'h0, RESP_OKAY);
    rd(OFF_MASK, SEC, 32'h0, RESP_OKAY);
    rd(OFF_MSTAT, NSEC, 32'h0, RESP_OKAY);
    rd(8'h3c, SEC, 32'h0, RESP_DECERR);
    // Every disabled source code allows a preload
    for (int c = 0; c < 16; c++) begin
      if (c == 0 || c > 9) begin
        pre = $random(seed);
        wr(OFF_CFG0, {26'h0, 4'(c), 2'h0}, NSEC, RESP_OKAY);
        wr(OFF_VAL0, pre, NSEC, RESP_OKAY);
        rd(OFF_VAL0, NSEC, pre, RESP_OKAY);
      end
    end
    // Active source ignores preloads; counting off keeps the count still
    wr(OFF_CFG0, 32'hffff_ff04, SEC, RESP_OKAY);
    rd(OFF_CFG0, SEC, 32'h04, RESP_OKAY);
    wr(OFF_VAL0, ~pre, SEC, RESP_OKAY);
    hits(0, 1'b0, 3);
    rd(OFF_VAL0, SEC, pre, RESP_OKAY);
    wr(OFF_CTRL, 32'h1, NSEC, RESP_OKAY);
    n = 1 + ($unsigned($random(seed)) % 7);
    hits(0, 1'b0, n);
    hits(1, 1'b0, 2);
    pre = f_cnt(pre, n, 1'b0, 1'b0);
    rd(OFF_VAL0, SEC, pre, RESP_OKAY);
    // Secure events count only with the debug pin high (2-flop sync delay)
    hits(0, 1'b1, 4);
    rd(OFF_VAL0, SEC, pre, RESP_OKAY);
    i_secure_debug_count_enable <= 1'b1;
    repeat (3) @(posedge i_core_clk);
    hits(0, 1'b1, 4);
    pre = f_cnt(pre, 4, 1'b1, 1'b1);
    rd(OFF_VAL0, SEC, pre, RESP_OKAY);
    // Each of the nine sources feeds counter 1
    for (int k = 1; k <= 9; k++) begin
      wr(OFF_CFG1, 32'h0, SEC, RESP_OKAY);
      wr(OFF_VAL1, 32'h0, SEC, RESP_OKAY);
      wr(OFF_CFG1, {26'h0, 4'(k), 2'h0}, SEC, RESP_OKAY);
      hits(k - 1, 1'b0, k);
      rd(OFF_VAL1, NSEC, 32'(k), RESP_OKAY);
    end
    // Reset bits clear one counter each and read as zero
    wr(OFF_CTRL, 32'h3, SEC, RESP_OKAY);
    rd(OFF_CTRL, SEC, 32'h1, RESP_OKAY);
    rd(OFF_VAL0, SEC, 32'h0, RESP_OKAY);
    rd(OFF_VAL1, SEC, 32'h9, RESP_OKAY);
    wr(OFF_CTRL, 32'h5, SEC, RESP_OKAY);
    rd(OFF_VAL1, SEC, 32'h0, RESP_OKAY);
    // Overflow wraps to zero and raises the counter source
    wr(OFF_CFG1, 32'h0, SEC, RESP_OKAY);
    wr(OFF_VAL1, 32'hffff_ffff, SEC, RESP_OKAY);
    wr(OFF_CFG1, {26'h0, 4'h2, GEN_OVF}, SEC, RESP_OKAY);
    wr(OFF_MASK, 32'h1ff, SEC, RESP_OKAY);
    irq_chk(9'h000);
    hits(1, 1'b0, 1);
    rd(OFF_VAL1, SEC, 32'h0, RESP_OKAY);
    irq_chk(9'h001);
    wr(OFF_CLR, 32'h1, SEC, RESP_OKAY);
    irq_chk(9'h000);
    wr(OFF_CFG1, 32'h0b, SEC, RESP_OKAY);
    hits(1, 1'b0, 2);
    irq_chk(9'h000);
    wr(OFF_CFG0, {26'h0, 4'h1, GEN_INC}, SEC, RESP_OKAY);
    hits(0, 1'b0, 1);
    irq_chk(9'h001);
    wr(OFF_CLR, 32'h1, SEC, RESP_OKAY);
    wr(OFF_CFG0, 32'h0, SEC, RESP_OKAY);
    // Random error burst against a random mask
    @(posedge i_core_clk);
    i_errors <= evcnt_err_t'($random(seed) | 1);
    @(posedge i_core_clk);
    raw = {i_errors, 1'b0};
    i_errors <= '0;
    msk = 9'($random(seed));
    wr(OFF_MASK, {23'h0, msk}, SEC, RESP_OKAY);
    irq_chk(raw & msk);
    rd(OFF_MSTAT, NSEC, f_msk(raw, msk), RESP_OKAY);
    rd(OFF_RAW, NSEC, {23'h0, raw}, RESP_OKAY);
    // Non-secure mask and clear access follows the auxiliary bit
    wr(OFF_MASK, 32'h0, NSEC, RESP_SLVERR);
    rd(OFF_MASK, NSEC, 32'h0, RESP_SLVERR);
    wr(OFF_CLR, 32'h1ff, NSEC, RESP_SLVERR);
    rd(OFF_RAW, SEC, {23'h0, raw}, RESP_OKAY);
    wr(OFF_MSTAT, 32'h0, SEC, RESP_SLVERR);
    wr(OFF_AUX, 32'h0800_0000, SEC, RESP_OKAY);
    wr(OFF_MASK, 32'hffff_ffff, NSEC, RESP_OKAY);
    rd(OFF_MASK, NSEC, 32'h1ff, RESP_OKAY);
    irq_chk(raw);
    wr(OFF_CLR, 32'h1ff, NSEC, RESP_OKAY);
    rd(OFF_RAW, NSEC, 32'h0, RESP_OKAY);
    irq_chk(9'h000);
    // An error held through a clear of its own bit must survive it
    i_errors.decode_err <= 1'b1;
    wr(OFF_CLR, 32'h100, SEC, RESP_OKAY);
    i_errors <= '0;
    rd(OFF_RAW, SEC, 32'h100, RESP_OKAY);
    irq_chk(9'h100);
    // Reset in mid-run brings mask, status, lines and counts back to zero
    i_reset_n <= 1'b0;
    repeat (2) @(posedge i_core_clk);
    i_reset_n <= 1'b1;
    repeat (2) @(posedge i_core_clk);
    irq_chk(9'h000);
    rd(OFF_MASK, SEC, 32'h0, RESP_OKAY);
    rd(OFF_MSTAT, NSEC, 32'h0, RESP_OKAY);
    rd(OFF_VAL1, SEC, 32'h0, RESP_OKAY);
    end_sim();
  end
endmodule // evcnt_unit_test
`default_nettype wire
